//--- hdl/fesctl_consts.vh
/*
 constants for the erase sequencer host controller.
 assumes word-mode bus, 21-bit word address, 8-bit command data.
*/
`ifndef FESCTL_CONSTS_VH
`define FESCTL_CONSTS_VH
`define FESCTL_AW 21
`define FESCTL_DW 16
`define FESCTL_UNLOCK1_ADDR 21'h000555
`define FESCTL_UNLOCK2_ADDR 21'h0002AA
`define FESCTL_UNLOCK1_DATA 16'h00AA
`define FESCTL_UNLOCK2_DATA 16'h0055
`define FESCTL_SETUP_DATA 16'h0080
`define FESCTL_CHIP_DATA 16'h0010
`define FESCTL_SECTOR_DATA 16'h0030
`define FESCTL_RESUME_DATA 16'h0030
`define FESCTL_SUSPEND_DATA 16'h00B0
`define FESCTL_SECT_HI 20
`define FESCTL_SECT_LO 12
`define FESCTL_SECT_W 9
`define FESCTL_BANK_HI 20
`define FESCTL_BANK_LO 19
`define FESCTL_CLK_MHZ 10
`define FESCTL_WINDOW_US 50
`define FESCTL_SPACE_US 40
`define FESCTL_SPACE_CYC 10'h190
`define FESCTL_WE_LOW_CYC 4
`define FESCTL_WE_HIGH_CYC 4
`define FESCTL_WE_LOW_LAST 4'h3
`define FESCTL_WE_HIGH_LAST 4'h3
`define FESCTL_RST_CYC 10'h008
`define FESCTL_CNT_W 10
`define FESCTL_CMD_CHIP 3'h1
`define FESCTL_CMD_SECTOR 3'h2
`define FESCTL_CMD_ADD 3'h3
`define FESCTL_CMD_SUSPEND 3'h4
`define FESCTL_CMD_RESUME 3'h5
`define FESCTL_CMD_ABORT 3'h6
`define FESCTL_POLARITY_BIT 7
`define FESCTL_WINDOW_BIT 3
`endif

//--- hdl/fesctl_bus_write.v
/*
 one asynchronous bus write cycle: drives address and data, pulses write strobe low.
 assumes chip enable held by caller and no reads in flight.
*/
`timescale 1ns/10ps
`include "fesctl_consts.vh"
`default_nettype none
module fesctl_bus_write (
  // system
  input wire clk_sys,
  input wire rst,
  // request
  input wire start,
  input wire [`FESCTL_AW-1:0] addr,
  input wire [`FESCTL_DW-1:0] data,
  output wire busy,
  output reg done_reg,
  // pins
  output reg [`FESCTL_AW-1:0] bus_addr_reg,
  output reg [`FESCTL_DW-1:0] bus_dout_reg,
  output reg bus_doe_reg,
  output reg bus_we_n_reg
);
  localparam S_IDLE = 3'b001;
  localparam S_LOW = 3'b010;
  localparam S_HIGH = 3'b100;
  reg [2:0] state_reg;
  reg [3:0] cnt_reg;
  assign busy = (state_reg != S_IDLE);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      bus_addr_reg <= {`FESCTL_AW{1'b0}};
      bus_dout_reg <= {`FESCTL_DW{1'b0}};
      bus_doe_reg <= 1'b0;
      bus_we_n_reg <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            bus_addr_reg <= addr;
            bus_dout_reg <= data;
            bus_doe_reg <= 1'b1;
            bus_we_n_reg <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= S_LOW;
          end
        end
        S_LOW: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `FESCTL_WE_LOW_LAST) begin
            bus_we_n_reg <= 1'b1;
            cnt_reg <= 4'h0;
            state_reg <= S_HIGH;
          end
        end
        S_HIGH: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `FESCTL_WE_HIGH_LAST) begin
            bus_doe_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- hdl/fesctl_host.v
/*
 host-side erase controller: issues chip erase, sector erase with queued
 sectors, erase suspend and resume as bus write sequences; samples status.
 assumes the flash is a word-mode device on an asynchronous parallel bus.
*/
// Contract
// - chip erase is six writes ending 10h
// - reset aborts; host reissues sequence
// - sector erase: five unlocks, then sector
// - host spaces queued writes under 50 us
// - suspend is B0h with bank address
// - resume with bank address; repeats ignored
// - sector chosen by address bits 20..12
`timescale 1ns/10ps
`include "fesctl_consts.vh"
`default_nettype none
module fesctl_host (
  // system
  input wire clk_sys,
  input wire rst,
  // user command port
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [`FESCTL_SECT_W-1:0] cmd_sector,
  input wire [1:0] cmd_bank,
  output wire cmd_ready,
  output reg cmd_done_reg,
  output reg cmd_dropped_reg,
  // status seen from the device
  output reg busy_reg,
  output reg completion_polarity_reg,
  output reg erase_window_reg,
  // flash pins
  output wire [`FESCTL_AW-1:0] flash_addr,
  output wire [`FESCTL_DW-1:0] flash_dq_out,
  output wire flash_dq_oe,
  input wire [`FESCTL_DW-1:0] flash_dq_in,
  output wire flash_we_n,
  output reg flash_oe_n_reg,
  output wire flash_ce_n,
  input wire ready_busy_output,
  output reg flash_reset_n_reg
);
  localparam S_IDLE = 5'b00001;
  localparam S_SEQ = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_POLL = 5'b01000;
  localparam S_RST = 5'b10000;
  reg [4:0] state_reg;
  reg [2:0] step_reg;
  reg [2:0] last_reg;
  reg [2:0] op_reg;
  reg [`FESCTL_AW-1:0] fin_addr_reg;
  reg [`FESCTL_DW-1:0] fin_data_reg;
  reg [`FESCTL_CNT_W-1:0] space_reg;
  reg [1:0] bank_reg;
  reg suspended_reg;
  reg window_open_reg;
  reg rb_meta_reg;
  reg rb_sync_reg;
  reg [`FESCTL_DW-1:0] dq_meta_reg;
  reg [`FESCTL_DW-1:0] dq_sync_reg;
  wire wr_start;
  reg [`FESCTL_AW-1:0] wr_addr;
  reg [`FESCTL_DW-1:0] wr_data;
  wire wr_busy;
  wire wr_done;
  wire [`FESCTL_AW-1:0] bank_addr;
  wire [`FESCTL_AW-1:0] sect_addr;

  fesctl_bus_write i_fesctl_bus_write (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(wr_start),
    .addr(wr_addr),
    .data(wr_data),
    .busy(wr_busy),
    .done_reg(wr_done),
    .bus_addr_reg(flash_addr),
    .bus_dout_reg(flash_dq_out),
    .bus_doe_reg(flash_dq_oe),
    .bus_we_n_reg(flash_we_n)
  );

  assign flash_ce_n = 1'b0;
  assign bank_addr = {cmd_bank, {(`FESCTL_AW-2){1'b0}}};
  // sector picked by upper address bits
  assign sect_addr = {cmd_sector, {`FESCTL_SECT_LO{1'b0}}};
  assign cmd_ready = (state_reg == S_IDLE);

  // pin inputs through two flops
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rb_meta_reg <= 1'b1;
      rb_sync_reg <= 1'b1;
      dq_meta_reg <= {`FESCTL_DW{1'b0}};
      dq_sync_reg <= {`FESCTL_DW{1'b0}};
    end else begin
      rb_meta_reg <= ready_busy_output;
      rb_sync_reg <= rb_meta_reg;
      dq_meta_reg <= flash_dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // unlock prefix table
  always @* begin
    wr_addr = `FESCTL_UNLOCK1_ADDR;
    wr_data = `FESCTL_UNLOCK1_DATA;
    case (step_reg)
      3'h0: wr_data = `FESCTL_UNLOCK1_DATA;
      3'h1: begin
        wr_addr = `FESCTL_UNLOCK2_ADDR;
        wr_data = `FESCTL_UNLOCK2_DATA;
      end
      3'h2: wr_data = `FESCTL_SETUP_DATA;
      3'h3: wr_data = `FESCTL_UNLOCK1_DATA;
      3'h4: begin
        wr_addr = `FESCTL_UNLOCK2_ADDR;
        wr_data = `FESCTL_UNLOCK2_DATA;
      end
      default: begin
        wr_addr = fin_addr_reg;
        wr_data = fin_data_reg;
      end
    endcase
    if (step_reg == last_reg) begin
      wr_addr = fin_addr_reg;
      wr_data = fin_data_reg;
    end
  end

  assign wr_start = (state_reg == S_SEQ) && !wr_busy && !wr_done;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      step_reg <= 3'h0;
      last_reg <= 3'h0;
      op_reg <= 3'h0;
      fin_addr_reg <= {`FESCTL_AW{1'b0}};
      fin_data_reg <= {`FESCTL_DW{1'b0}};
      space_reg <= {`FESCTL_CNT_W{1'b0}};
      bank_reg <= 2'h0;
      suspended_reg <= 1'b0;
      window_open_reg <= 1'b0;
      cmd_done_reg <= 1'b0;
      cmd_dropped_reg <= 1'b0;
      busy_reg <= 1'b0;
      completion_polarity_reg <= 1'b0;
      erase_window_reg <= 1'b0;
      flash_oe_n_reg <= 1'b1;
      flash_reset_n_reg <= 1'b1;
    end else begin
      cmd_done_reg <= 1'b0;
      cmd_dropped_reg <= 1'b0;
      // status sampled from device pins
      busy_reg <= !rb_sync_reg;
      completion_polarity_reg <= dq_sync_reg[`FESCTL_POLARITY_BIT];
      erase_window_reg <= dq_sync_reg[`FESCTL_WINDOW_BIT];
      if (space_reg != {`FESCTL_CNT_W{1'b0}}) begin
        space_reg <= space_reg - {{(`FESCTL_CNT_W-1){1'b0}}, 1'b1};
      end else begin
        window_open_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid) begin
            op_reg <= cmd_op;
            step_reg <= 3'h0;
            case (cmd_op)
              `FESCTL_CMD_CHIP: begin
                if (busy_reg || suspended_reg) begin
                  cmd_dropped_reg <= 1'b1;
                end else begin
                  last_reg <= 3'h5;
                  fin_addr_reg <= `FESCTL_UNLOCK1_ADDR;
                  fin_data_reg <= `FESCTL_CHIP_DATA;
                  state_reg <= S_SEQ;
                end
              end
              `FESCTL_CMD_SECTOR: begin
                if (busy_reg || suspended_reg) begin
                  cmd_dropped_reg <= 1'b1;
                end else begin
                  last_reg <= 3'h5;
                  bank_reg <= cmd_bank;
                  fin_addr_reg <= sect_addr;
                  fin_data_reg <= `FESCTL_SECTOR_DATA;
                  state_reg <= S_SEQ;
                end
              end
              `FESCTL_CMD_ADD: begin
                // queued sector only while our window is still open
                if (window_open_reg && cmd_bank == bank_reg) begin
                  last_reg <= 3'h0;
                  fin_addr_reg <= sect_addr;
                  fin_data_reg <= `FESCTL_SECTOR_DATA;
                  state_reg <= S_SEQ;
                end else begin
                  cmd_dropped_reg <= 1'b1;
                end
              end
              `FESCTL_CMD_SUSPEND: begin
                if ((window_open_reg || busy_reg) && !suspended_reg
                    && fin_data_reg != `FESCTL_CHIP_DATA) begin
                  last_reg <= 3'h0;
                  fin_addr_reg <= bank_addr;
                  fin_data_reg <= `FESCTL_SUSPEND_DATA;
                  state_reg <= S_SEQ;
                end else begin
                  cmd_dropped_reg <= 1'b1;
                end
              end
              `FESCTL_CMD_RESUME: begin
                if (suspended_reg) begin
                  last_reg <= 3'h0;
                  fin_addr_reg <= bank_addr;
                  fin_data_reg <= `FESCTL_RESUME_DATA;
                  state_reg <= S_SEQ;
                end else begin
                  cmd_dropped_reg <= 1'b1;
                end
              end
              `FESCTL_CMD_ABORT: begin
                flash_reset_n_reg <= 1'b0;
                suspended_reg <= 1'b0;
                space_reg <= `FESCTL_RST_CYC;
                state_reg <= S_RST;
              end
              default: cmd_dropped_reg <= 1'b1;
            endcase
          end
        end
        S_SEQ: begin
          if (wr_done) begin
            if (step_reg == last_reg) begin
              state_reg <= S_WAIT;
            end else begin
              step_reg <= step_reg + 3'h1;
            end
          end
        end
        S_WAIT: begin
          // final write cycle ended after its strobe high span; timing counted from here
          cmd_done_reg <= 1'b1;
          state_reg <= S_IDLE;
          case (op_reg)
            `FESCTL_CMD_SECTOR, `FESCTL_CMD_ADD: begin
              window_open_reg <= 1'b1;
              space_reg <= `FESCTL_SPACE_CYC;
            end
            `FESCTL_CMD_SUSPEND: begin
              suspended_reg <= 1'b1;
              window_open_reg <= 1'b0;
              space_reg <= {`FESCTL_CNT_W{1'b0}};
              state_reg <= S_POLL;
            end
            `FESCTL_CMD_RESUME: suspended_reg <= 1'b0;
            default: ;
          endcase
        end
        S_RST: begin
          if (space_reg == {`FESCTL_CNT_W{1'b0}}) begin
            flash_reset_n_reg <= 1'b1;
            cmd_done_reg <= 1'b1;
            state_reg <= S_POLL;
          end
        end
        S_POLL: begin
          // wait for ready before suspend-read access
          if (rb_sync_reg) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/fesctl_host_chk.sv
/* port checker for the host erase controller
 watches top ports only; bound from the bench */
`timescale 1ns/10ps
`default_nettype none
`include "fesctl_consts.vh"
module fesctl_host_chk (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // user side
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic cmd_ready,
  input wire logic cmd_done_reg,
  input wire logic cmd_dropped_reg,
  input wire logic busy_reg,
  input wire logic erase_window_reg,
  // flash side
  input wire logic [`FESCTL_AW-1:0] flash_addr,
  input wire logic [`FESCTL_DW-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic [`FESCTL_DW-1:0] flash_dq_in,
  input wire logic flash_we_n,
  input wire logic ready_busy_output
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_we_low_span: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("write strobe low span wrong");
  a_we_high_gap: assert property ($rose(flash_we_n) |-> flash_we_n [*4])
    else $error("write strobe high span too short");
  a_oe_covers: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data not driven during strobe");
  a_strobe_hold: assert property (!flash_we_n && !$past(flash_we_n) |->
    $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved during strobe");
  a_erase_answer: assert property (cmd_valid && cmd_ready && (cmd_op == 3'h1 || cmd_op == 3'h2)
    |-> (##1 cmd_dropped_reg) or (##[60:64] cmd_done_reg))
    else $error("six-write sequence answer mistimed");
  a_resume_answer: assert property (cmd_valid && cmd_ready && cmd_op == 3'h5
    |-> (##1 cmd_dropped_reg) or (##[8:12] cmd_done_reg))
    else $error("resume answer mistimed");
  a_busy_follow: assert property ($fell(ready_busy_output) |-> ##[1:4] busy_reg)
    else $error("busy flag missed device busy");
  a_window_follow: assert property ($rose(flash_dq_in[3]) |-> ##[1:4] erase_window_reg)
    else $error("window flag missed");
  a_ready_idle: assert property (cmd_ready |-> flash_we_n)
    else $error("strobe while idle");
endmodule
`default_nettype wire

//--- verification/fesctl_flash_model.sv
/* behavioural flash bank answering erase command sequences
 status always on its own data lines; bench resolves the bus */
`timescale 1ns/10ps
`default_nettype none
module fesctl_flash_model #(
  parameter WIN_NS = 50000,
  parameter ERASE_NS = 100000,
  parameter CHIP_NS = 150000,
  parameter SUSP_NS = 5000
) (
  // bus
  input wire logic [20:0] addr,
  input wire logic [15:0] dq,
  input wire logic we_n,
  input wire logic reset_n,
  // status
  output wire logic [15:0] status_dq,
  output wire logic ready_busy
);
  // read 0, chip 1, window 2, erasing 3, halting 4, suspended 5
  int st = 0;
  int n = 0;
  time t_evt = 0;
  logic [7:0] d;
  assign ready_busy = st == 0 || st == 5;
  assign status_dq = {8'h00, ready_busy, 3'h0, st == 1 || st > 2, 3'h0};
  function automatic logic seq_ok(int k, logic [20:0] a, logic [7:0] v);
    if (k == 1 || k == 4)
      return a[10:0] == 11'h2AA && v == 8'h55;
    return a[10:0] == 11'h555 && v == (k == 2 ? 8'h80 : 8'hAA);
  endfunction
  always @(posedge we_n) if (reset_n) begin
    d = dq[7:0];
    case (st)
      0: begin
        if (n == 5 && d == 8'h10 && addr[10:0] == 11'h555) begin
          st = 1;
          t_evt = $time + CHIP_NS;
        end else if (n == 5 && d == 8'h30) begin
          st = 2;
          t_evt = $time + WIN_NS;
        end
        n = (n < 5 && seq_ok(n, addr, d)) ? n + 1 : 0;
      end
      2: begin
        if (d == 8'h30)
          t_evt = $time + WIN_NS;
        else
          st = d == 8'hB0 ? 5 : 0;
      end
      3: begin
        if (d == 8'hB0) begin
          st = 4;
          t_evt = $time + SUSP_NS;
        end
      end
      5: begin
        if (d == 8'h30) begin
          st = 3;
          t_evt = $time + ERASE_NS;
        end
      end
      default: ;
    endcase
  end
  always @(negedge reset_n) begin
    st = 0;
    n = 0;
  end
  always #100 if (st != 0 && st != 5 && $time >= t_evt) begin
    if (st == 2) begin
      st = 3;
      t_evt = $time + ERASE_NS;
    end else
      st = st == 4 ? 5 : 0;
  end
endmodule
`default_nettype wire

//--- verification/fesctl_host_test.sv
/* self-checking bench for the host erase controller
 user port driven on falling edges; flash model on the pins */
`timescale 1ns/10ps
`default_nettype none
`include "fesctl_consts.vh"
module fesctl_host_test;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid = 1'h0;
  logic [2:0] cmd_op = 3'h0;
  logic [`FESCTL_SECT_W-1:0] cmd_sector = 9'h000;
  logic [1:0] cmd_bank = 2'h0;
  wire cmd_ready, cmd_done_reg, cmd_dropped_reg, busy_reg, completion_polarity_reg;
  wire erase_window_reg, flash_dq_oe, flash_we_n, flash_oe_n_reg, flash_ce_n;
  wire ready_busy_output, flash_reset_n_reg;
  wire [`FESCTL_AW-1:0] flash_addr;
  wire [`FESCTL_DW-1:0] flash_dq_out, flash_dq_in, dev_dq;
  int mismatches = 0;
  int samples_checked = 0;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_dq;
  initial forever #50 clk_sys = ~clk_sys;
  fesctl_host i_fesctl_host (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_sector(cmd_sector), .cmd_bank(cmd_bank), .cmd_ready(cmd_ready),
    .cmd_done_reg(cmd_done_reg), .cmd_dropped_reg(cmd_dropped_reg), .busy_reg(busy_reg),
    .completion_polarity_reg(completion_polarity_reg), .erase_window_reg(erase_window_reg),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .flash_we_n(flash_we_n), .flash_oe_n_reg(flash_oe_n_reg),
    .flash_ce_n(flash_ce_n), .ready_busy_output(ready_busy_output),
    .flash_reset_n_reg(flash_reset_n_reg));
  fesctl_flash_model i_fesctl_flash_model (.addr(flash_addr), .dq(flash_dq_out),
    .we_n(flash_we_n), .reset_n(flash_reset_n_reg), .status_dq(dev_dq),
    .ready_busy(ready_busy_output));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request; exp 1 when it should be written, 0 when refused
  task automatic do_cmd(input logic [2:0] op, input logic [8:0] sec, input logic [1:0] bk,
      input logic exp);
    int i;
    @(negedge clk_sys);
    cmd_op = op;
    cmd_sector = sec;
    cmd_bank = bk;
    cmd_valid = 1'h1;
    for (i = 0; i < 3000 && cmd_ready !== 1'h1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'h0;
    for (i = 0; i < 3000; i++) begin
      if (cmd_done_reg === 1'h1 || cmd_dropped_reg === 1'h1) break;
      @(negedge clk_sys);
    end
    chk({cmd_dropped_reg, cmd_done_reg}, {!exp, exp});
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 4000 && busy_reg !== v; i++) @(negedge clk_sys);
    chk(busy_reg, v);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(40000 * 100);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'h0;
    // chip erase refuses sector erase and suspend
    do_cmd(3'h1, 9'h000, 2'h0, 1'h1);
    wait_busy(1'h1);
    chk(completion_polarity_reg, 1'h0);
    do_cmd(3'h2, 9'h005, 2'h0, 1'h0);
    do_cmd(3'h4, 9'h000, 2'h0, 1'h0);
    wait_busy(1'h0);
    chk(completion_polarity_reg, 1'h1);
    // idle bank: nothing to resume or queue into
    do_cmd(3'h5, 9'h000, 2'h0, 1'h0);
    do_cmd(3'h3, 9'h009, 2'h0, 1'h0);
    // queued sectors, suspend inside the window
    do_cmd(3'h2, 9'h005, 2'h0, 1'h1);
    do_cmd(3'h3, 9'h001, 2'h0, 1'h1);
    do_cmd(3'h3, 9'h1FF, 2'h3, 1'h0);
    chk(erase_window_reg, 1'h0);
    do_cmd(3'h4, 9'h000, 2'h0, 1'h1);
    wait_busy(1'h0);
    do_cmd(3'h2, 9'h002, 2'h0, 1'h0);
    do_cmd(3'h5, 9'h000, 2'h0, 1'h1);
    wait_busy(1'h1);
    repeat (4) @(negedge clk_sys);
    chk(erase_window_reg, 1'h1);
    do_cmd(3'h5, 9'h000, 2'h0, 1'h0);
    do_cmd(3'h4, 9'h000, 2'h0, 1'h1);
    do_cmd(3'h5, 9'h000, 2'h0, 1'h1);
    wait_busy(1'h1);
    wait_busy(1'h0);
    // window lapses, late sector refused
    do_cmd(3'h2, 9'h010, 2'h0, 1'h1);
    repeat (520) @(negedge clk_sys);
    chk(erase_window_reg, 1'h1);
    do_cmd(3'h3, 9'h011, 2'h0, 1'h0);
    wait_busy(1'h0);
    chk({flash_oe_n_reg, flash_ce_n}, 16'h0002);
    // reset pulse aborts a running erase, then the host reissues
    do_cmd(3'h2, 9'h012, 2'h0, 1'h1);
    do_cmd(3'h6, 9'h000, 2'h0, 1'h1);
    chk(busy_reg, 1'h0);
    do_cmd(3'h2, 9'h012, 2'h0, 1'h1);
    wait_busy(1'h1);
    wait_busy(1'h0);
    tally_and_finish;
  end
endmodule
bind fesctl_host fesctl_host_chk i_fesctl_host_chk (.clk_sys(clk_sys), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .cmd_done_reg(cmd_done_reg),
  .cmd_dropped_reg(cmd_dropped_reg), .busy_reg(busy_reg), .erase_window_reg(erase_window_reg),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_dq_in(flash_dq_in), .flash_we_n(flash_we_n), .ready_busy_output(ready_busy_output));
`default_nettype wire
